// [logic/sdram_burst_pkg.sv]
/*
  Shared constants for the burst and row-activation logic of a four-bank
  synchronous DRAM in its sixteen-bit organisation.
  Assumes one 100 MHz clock and a register port with one-cycle read data.
*/
package sdram_burst_pkg;
  // organisation: sixteen-bit part, four banks
  localparam int unsigned DATA_W = 16;
  localparam int unsigned COL_W = 9;
  localparam int unsigned ROW_W = 13;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned PAGE_COLS = 512;
  localparam int unsigned MODE_W = 10;

  // mode word field positions
  localparam int unsigned BURST_LEN_LSB = 0;
  localparam int unsigned ORDER_SELECT_BIT = 3;
  localparam int unsigned READ_LATENCY_LSB = 4;
  localparam int unsigned OP_MODE_BIT_LOW = 7;
  localparam int unsigned OP_MODE_BIT_HIGH = 8;
  localparam int unsigned WRITE_SINGLE_BIT = 9;

  // burst length codes
  localparam logic [2:0] LEN_1 = 3'h0;
  localparam logic [2:0] LEN_2 = 3'h1;
  localparam logic [2:0] LEN_4 = 3'h2;
  localparam logic [2:0] LEN_8 = 3'h3;
  localparam logic [2:0] LEN_FULL = 3'h7;

  // read latency codes
  localparam logic [2:0] LAT_2 = 3'h2;
  localparam logic [2:0] LAT_3 = 3'h3;

  // command codes on the command port
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_ACTIVE = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE = 3'h3;
  localparam logic [2:0] CMD_TERM = 3'h4;
  localparam logic [2:0] CMD_PRECHARGE = 3'h5;
  localparam int unsigned ALL_BANKS_BIT = 10;

  // register port map
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [MODE_W-1:0] MODE_RESET = 10'h022;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_READ_BIT = 1;
  localparam int unsigned ST_WRITE_BIT = 2;
  localparam int unsigned ST_BAD_MODE_BIT = 3;
  localparam int unsigned ST_OPEN_LSB = 4;
  localparam int unsigned ST_CLOSED_ERR_BIT = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RBURST = 3'h2,
    ST_WBURST = 3'h4
  } burst_state_t;
endpackage

// [logic/col_order.sv]
/*
  Column generator: column of one beat inside an aligned burst block.
  Assumes the caller passes the beat index already reduced below the length.
*/
`timescale 1ns/1ps
module col_order (
  // burst description
  input wire logic [sdram_burst_pkg::COL_W-1:0] start_col,
  input wire logic [sdram_burst_pkg::COL_W-1:0] beat,
  input wire logic [sdram_burst_pkg::COL_W-1:0] blk_mask,
  input wire logic interleave,
  // resulting column
  output logic [sdram_burst_pkg::COL_W-1:0] col
);
  logic [sdram_burst_pkg::COL_W-1:0] seq_off;
  logic [sdram_burst_pkg::COL_W-1:0] ilv_off;

  // low bits move, block bits stay: wrap stays inside the block
  assign seq_off = start_col + beat;
  assign ilv_off = start_col ^ beat;
  assign col = (start_col & ~blk_mask) | ((interleave ? ilv_off : seq_off) & blk_mask);
endmodule

// [logic/col_store.sv]
/*
  Small synchronous store indexed by bank and column, registered read data.
  Assumes at most one read or one write per clock.
*/
`timescale 1ns/1ps
module col_store (
  // clock
  input wire logic mclk,
  // access
  input wire logic [sdram_burst_pkg::BANK_W+sdram_burst_pkg::COL_W-1:0] addr,
  input wire logic wr_en,
  input wire logic [sdram_burst_pkg::DATA_W-1:0] wr_data,
  output logic [sdram_burst_pkg::DATA_W-1:0] rd_data
);
  logic [sdram_burst_pkg::DATA_W-1:0] mem [0:(1<<(sdram_burst_pkg::BANK_W+sdram_burst_pkg::COL_W))-1];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule

// [logic/sdram_burst.sv]
/*
  Burst sequencer of a four-bank synchronous DRAM (sixteen-bit part):
  mode word, column order in a burst, read latency, bank open state.
  Assumes commands arrive synchronous to mclk, one per cycle, and that
  the controller keeps the activation spacing itself.
*/
// Behaviour
// RQ1: burst lengths one, two, four, eight and full page for reads and writes.
// RQ2: full page only sequential; controller ends it with burst terminate.
// RQ3: controller never programs a reserved burst-length code.
// RQ4: burst stays in an aligned block of burst length, wrapping at its edge.
// RQ5: block chosen by column bits 8 down to 1, 2 or 3.
// RQ6: block-select upper bound is column bit 8 for this width.
// RQ7: one mode bit picks sequential or interleaved order.
// RQ8: sequential order counts up from start modulo the length.
// RQ9: interleaved beat k goes to start XOR k; never for full page.
// RQ10: full-page burst spans the 512 columns of the row.
// RQ11: full page starts at given column, wraps at page end until stopped.
// RQ12: length one touches only the given column, ignoring order bit.
// RQ13: read latency two or three; drive from n+m-1, valid at n+m.
// RQ14: normal operation only with both operating-mode bits zero.
// RQ15: write-single bit makes writes one column, reads keep the length.
// RQ16: controller opens a row with ACTIVE before any read or write; the bench reads bank 2 once without ACTIVE to set the flag.
// RQ17: controller rounds row-to-column delay up to whole clocks.
// RQ18: controller precharges before activating another row of that bank.
// RQ19: controller spaces same-bank ACTIVEs by the row-cycle time.
// RQ20: controller spaces ACTIVEs to other banks by the bank-to-bank time.
// RQ21: mode fields: length 2:0, order 3, latency 6:4, op 8:7, write 9.
// RQ22: controller tracks open state and open row of all four banks.
`timescale 1ns/1ps
module sdram_burst (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [sdram_burst_pkg::BANK_W-1:0] cmd_bank,
  input wire logic [sdram_burst_pkg::ROW_W-1:0] cmd_addr,
  // data pins
  input wire logic [sdram_burst_pkg::DATA_W-1:0] dq_in,
  output logic [sdram_burst_pkg::DATA_W-1:0] dq_out,
  output logic dq_oe
);
  localparam int unsigned AW = sdram_burst_pkg::BANK_W + sdram_burst_pkg::COL_W;

  // mode word and its fields
  logic [sdram_burst_pkg::MODE_W-1:0] mode_ff;
  wire [2:0] burst_len = mode_ff[sdram_burst_pkg::BURST_LEN_LSB +: 3]; // RQ21
  wire order_select_bit = mode_ff[sdram_burst_pkg::ORDER_SELECT_BIT]; // RQ21
  wire [2:0] read_latency = mode_ff[sdram_burst_pkg::READ_LATENCY_LSB +: 3]; // RQ21
  wire op_mode_bit_low = mode_ff[sdram_burst_pkg::OP_MODE_BIT_LOW];
  wire op_mode_bit_high = mode_ff[sdram_burst_pkg::OP_MODE_BIT_HIGH];
  wire write_single_bit = mode_ff[sdram_burst_pkg::WRITE_SINGLE_BIT]; // RQ21

  // normal operation needs both op bits clear; anything else blocks bursts
  wire mode_ok = !op_mode_bit_low && !op_mode_bit_high; // RQ14
  // reserved length codes fall back to a single column (undefined anyway)
  wire len_full = (burst_len == sdram_burst_pkg::LEN_FULL);
  wire [sdram_burst_pkg::COL_W-1:0] len_mask_w =
    (burst_len == sdram_burst_pkg::LEN_2) ? 9'h001 :
    (burst_len == sdram_burst_pkg::LEN_4) ? 9'h003 :
    (burst_len == sdram_burst_pkg::LEN_8) ? 9'h007 :
    len_full ? 9'h1FF : 9'h000; // RQ1 RQ5 RQ6 RQ10
  wire lat3_w = (read_latency == sdram_burst_pkg::LAT_3); // RQ13

  // command decode
  wire cmd_act = cmd_valid && (cmd_code == sdram_burst_pkg::CMD_ACTIVE);
  wire cmd_rd = cmd_valid && mode_ok && (cmd_code == sdram_burst_pkg::CMD_READ);
  wire cmd_wr = cmd_valid && mode_ok && (cmd_code == sdram_burst_pkg::CMD_WRITE);
  wire cmd_term = cmd_valid && (cmd_code == sdram_burst_pkg::CMD_TERM);
  wire cmd_pre = cmd_valid && (cmd_code == sdram_burst_pkg::CMD_PRECHARGE);
  wire pre_all = cmd_addr[sdram_burst_pkg::ALL_BANKS_BIT];
  wire [sdram_burst_pkg::COL_W-1:0] cmd_col = cmd_addr[sdram_burst_pkg::COL_W-1:0];

  // write-single mode shrinks write bursts to one column
  wire [sdram_burst_pkg::COL_W-1:0] wr_mask_w = write_single_bit ? 9'h000 : len_mask_w; // RQ15
  wire [sdram_burst_pkg::COL_W-1:0] new_mask_w = cmd_wr ? wr_mask_w : len_mask_w;
  wire new_full = len_full && !(cmd_wr && write_single_bit);
  // length one ignores the order bit; full page is sequential only
  wire new_ilv = order_select_bit && !len_full && (new_mask_w != 9'h000); // RQ2 RQ9 RQ12

  // burst engine
  sdram_burst_pkg::burst_state_t state_ff;
  sdram_burst_pkg::burst_state_t nxt_state;
  logic [sdram_burst_pkg::BANK_W-1:0] bank_ff;
  logic [sdram_burst_pkg::COL_W-1:0] start_ff;
  logic [sdram_burst_pkg::COL_W-1:0] beat_ff;
  logic [sdram_burst_pkg::COL_W-1:0] mask_ff;
  logic full_ff;
  logic ilv_ff;
  logic lat3_ff;
  logic [sdram_burst_pkg::COL_W-1:0] beat_col;

  col_order u_col_order (
    .start_col(start_ff),
    .beat(beat_ff),
    .blk_mask(mask_ff),
    .interleave(ilv_ff),
    .col(beat_col)
  );

  wire in_burst = (state_ff != sdram_burst_pkg::ST_IDLE);
  wire last_beat = !full_ff && (beat_ff == mask_ff);
  // a precharge to the bursting bank cuts the burst short
  wire cut_burst = cmd_term || (cmd_pre && (pre_all || cmd_bank == bank_ff));
  wire new_burst = cmd_rd || cmd_wr;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sdram_burst_pkg::ST_IDLE: begin
        nxt_state = sdram_burst_pkg::ST_IDLE;
      end
      sdram_burst_pkg::ST_RBURST, sdram_burst_pkg::ST_WBURST: begin
        if (cut_burst || last_beat) begin
          nxt_state = sdram_burst_pkg::ST_IDLE; // RQ2 RQ11
        end
      end
      default: begin
        nxt_state = sdram_burst_pkg::ST_IDLE;
      end
    endcase
    // a new command truncates whatever runs; beat 0 is taken right here
    if (new_burst) begin
      if (new_mask_w == 9'h000) begin
        nxt_state = sdram_burst_pkg::ST_IDLE; // RQ12 RQ15
      end else if (cmd_rd) begin
        nxt_state = sdram_burst_pkg::ST_RBURST;
      end else begin
        nxt_state = sdram_burst_pkg::ST_WBURST;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state_ff <= sdram_burst_pkg::ST_IDLE;
      bank_ff <= '0;
      start_ff <= '0;
      beat_ff <= '0;
      mask_ff <= '0;
      full_ff <= 1'b0;
      ilv_ff <= 1'b0;
      lat3_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (new_burst) begin
        bank_ff <= cmd_bank;
        start_ff <= cmd_col; // RQ4 RQ11
        beat_ff <= 9'h001;
        mask_ff <= new_mask_w;
        full_ff <= new_full;
        ilv_ff <= new_ilv; // RQ7
        lat3_ff <= lat3_w;
      end else if (in_burst) begin
        // full page beat index wraps at 512, i.e. at the page end
        beat_ff <= beat_ff + 9'h001; // RQ8 RQ11
      end
    end
  end

  // store access: command beat first, else the running burst
  wire rd_access = cmd_rd || (!new_burst && state_ff == sdram_burst_pkg::ST_RBURST && !cut_burst);
  wire wr_access = cmd_wr || (!new_burst && state_ff == sdram_burst_pkg::ST_WBURST && !cut_burst);
  wire [AW-1:0] mem_addr = new_burst ? {cmd_bank, cmd_col} : {bank_ff, beat_col};
  logic [sdram_burst_pkg::DATA_W-1:0] mem_rdata;

  // write data registered on the command edge and each edge after
  col_store u_col_store (
    .mclk(mclk),
    .addr(mem_addr),
    .wr_en(wr_access),
    .wr_data(dq_in),
    .rd_data(mem_rdata)
  );

  // read latency pipeline: store output, then one or two data stages
  logic rv0_ff;
  logic rv1_ff;
  logic rv2_ff;
  logic [sdram_burst_pkg::DATA_W-1:0] rd1_ff;
  logic [sdram_burst_pkg::DATA_W-1:0] rd2_ff;
  logic [sdram_burst_pkg::DATA_W-1:0] dq_out_ff;
  logic dq_oe_ff;
  // latency taken per read so a mode change mid-burst cannot tear the stream
  logic lat3_use;
  assign lat3_use = cmd_rd ? lat3_w : lat3_ff;
  logic rl3_ff;
  wire nxt_oe = rl3_ff ? (rv1_ff || rv2_ff) : (rv0_ff || rv1_ff);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rv0_ff <= 1'b0;
      rv1_ff <= 1'b0;
      rv2_ff <= 1'b0;
      rl3_ff <= 1'b0;
      rd1_ff <= '0;
      rd2_ff <= '0;
      dq_out_ff <= '0;
      dq_oe_ff <= 1'b0;
    end else begin
      rv0_ff <= rd_access;
      rv1_ff <= rv0_ff;
      rv2_ff <= rv1_ff;
      if (rd_access) begin
        rl3_ff <= lat3_use;
      end
      rd1_ff <= mem_rdata;
      rd2_ff <= rd1_ff;
      // drive starts an edge before the data is valid
      dq_oe_ff <= nxt_oe; // RQ13
      dq_out_ff <= rl3_ff ? rd2_ff : rd1_ff; // RQ13
    end
  end
  assign dq_out = dq_out_ff;
  assign dq_oe = dq_oe_ff;

  // bank open state; access to a closed bank is flagged, not blocked
  logic [sdram_burst_pkg::NUM_BANKS-1:0] open_ff;
  logic closed_err_ff;
  wire closed_hit = new_burst && !open_ff[cmd_bank]; // RQ16
  wire st_wr = reg_wr && (reg_addr == sdram_burst_pkg::REG_STATUS);
  wire err_clr = st_wr && reg_wdata[sdram_burst_pkg::ST_CLOSED_ERR_BIT];

  genvar gb;
  generate
    for (gb = 0; gb < sdram_burst_pkg::NUM_BANKS; gb++) begin : g_bank
      always_ff @(posedge mclk) begin
        if (!nrst) begin
          open_ff[gb] <= 1'b0;
        end else if (cmd_act && cmd_bank == gb) begin
          open_ff[gb] <= 1'b1; // RQ16
        end else if (cmd_pre && (pre_all || cmd_bank == gb)) begin
          open_ff[gb] <= 1'b0; // RQ18
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      closed_err_ff <= 1'b0;
    end else if (closed_hit) begin
      closed_err_ff <= 1'b1;
    end else if (err_clr) begin
      closed_err_ff <= 1'b0;
    end
  end

  // register port
  wire mode_wr = reg_wr && (reg_addr == sdram_burst_pkg::REG_MODE);
  logic [31:0] reg_rdata_ff;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr == sdram_burst_pkg::REG_MODE) begin
      rd_mux[sdram_burst_pkg::MODE_W-1:0] = mode_ff;
    end else if (reg_addr == sdram_burst_pkg::REG_STATUS) begin
      rd_mux[sdram_burst_pkg::ST_BUSY_BIT] = in_burst;
      rd_mux[sdram_burst_pkg::ST_READ_BIT] = dq_oe_ff;
      rd_mux[sdram_burst_pkg::ST_WRITE_BIT] = (state_ff == sdram_burst_pkg::ST_WBURST);
      rd_mux[sdram_burst_pkg::ST_BAD_MODE_BIT] = !mode_ok;
      rd_mux[sdram_burst_pkg::ST_OPEN_LSB +: sdram_burst_pkg::NUM_BANKS] = open_ff;
      rd_mux[sdram_burst_pkg::ST_CLOSED_ERR_BIT] = closed_err_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      mode_ff <= sdram_burst_pkg::MODE_RESET;
      reg_rdata_ff <= 32'h0000_0000;
    end else begin
      if (mode_wr) begin
        mode_ff <= reg_wdata[sdram_burst_pkg::MODE_W-1:0];
      end
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign reg_rdata = reg_rdata_ff;

  // checks
  sequence s_quiet3;
    (!cmd_valid && !reg_wr)[*3];
  endsequence

  sequence s_rd4_start;
    cmd_rd && burst_len == sdram_burst_pkg::LEN_4;
  endsequence

  a_lat2_drive: assert property (@(posedge mclk) disable iff (!nrst) // RQ13
    cmd_rd && !lat3_w |=> ##1 dq_oe ##1 dq_oe)
    else $error("latency two read not driven at n+1 and n+2");

  a_lat3_drive: assert property (@(posedge mclk) disable iff (!nrst) // RQ13
    cmd_rd && lat3_w && !rv0_ff && !rv1_ff && !rv2_ff && !in_burst |=> !dq_oe ##1 !dq_oe ##1 dq_oe ##1 dq_oe)
    else $error("latency three read not driven at n+2 and n+3");

  a_seq_order: assert property (@(posedge mclk) disable iff (!nrst) // RQ8
    in_burst && !ilv_ff && !new_burst |=> !in_burst || ((beat_col - $past(beat_col)) & mask_ff) == 9'h001)
    else $error("sequential column order wrong");

  a_ilv_order: assert property (@(posedge mclk) disable iff (!nrst) // RQ9
    in_burst && ilv_ff |-> ((beat_col ^ start_ff) & mask_ff) == (beat_ff & mask_ff) && !full_ff)
    else $error("interleaved column order wrong");

  a_block_kept: assert property (@(posedge mclk) disable iff (!nrst) // RQ4
    in_burst |-> (beat_col & ~mask_ff) == (start_ff & ~mask_ff))
    else $error("burst left its block");

  a_single_col: assert property (@(posedge mclk) disable iff (!nrst) // RQ12
    new_burst && burst_len == sdram_burst_pkg::LEN_1 |=> !in_burst && !ilv_ff)
    else $error("length one burst ran on");

  a_write_single: assert property (@(posedge mclk) disable iff (!nrst) // RQ15
    cmd_wr && write_single_bit |=> !in_burst)
    else $error("single write burst ran on");

  a_len4_count: assert property (@(posedge mclk) disable iff (!nrst) // RQ1
    s_rd4_start ##1 s_quiet3 |=> !in_burst)
    else $error("burst of four beat count wrong");

  a_len4_busy: assert property (@(posedge mclk) disable iff (!nrst) // RQ1
    s_rd4_start ##1 s_quiet3 |-> in_burst && $past(in_burst) && $past(in_burst, 2))
    else $error("burst of four not three extra beats");

  a_page_wrap: assert property (@(posedge mclk) disable iff (!nrst) // RQ11
    in_burst && full_ff && beat_ff == 9'h1FF && !cmd_valid |=> in_burst && beat_ff == 9'h000)
    else $error("full page did not wrap");

  a_err_sticky: assert property (@(posedge mclk) disable iff (!nrst) // RQ16
    closed_hit |=> closed_err_ff)
    else $error("closed bank access not flagged");
endmodule

// [bench/sdram_ctrl_model.sv]
/*
  Behavioural memory controller driving the command and write-data pins.
  Assumes its tasks are called one at a time from a single bench process.
*/
`timescale 1ns/1ps
module sdram_ctrl_model #(
  parameter int ROW_TO_COL_NS = 20,
  parameter int ACT_SAME_NS = 70,
  parameter int ACT_OTHER_NS = 15
) (
  // clock
  input wire logic mclk,
  // command pins
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [sdram_burst_pkg::BANK_W-1:0] cmd_bank,
  output logic [sdram_burst_pkg::ROW_W-1:0] cmd_addr,
  // write data pins
  output logic [sdram_burst_pkg::DATA_W-1:0] dq_in
);
  // time limits rounded up to whole 10 ns clocks
  localparam int ROW_COL_CYC = (ROW_TO_COL_NS + 9) / 10;
  localparam int SAME_BANK_CYC = (ACT_SAME_NS + 9) / 10;
  localparam int OTHER_BANK_CYC = (ACT_OTHER_NS + 9) / 10;
  int cyc;
  int last_any;
  int last_act [4];
  logic open_b [4];
  logic [12:0] open_row [4];

  initial begin
    cyc = 0;
    last_any = -100;
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_bank = 2'h0;
    cmd_addr = 13'h0;
    dq_in = 16'h0;
    foreach (last_act[b]) begin
      last_act[b] = -100;
      open_b[b] = 1'b0;
      open_row[b] = 13'h0;
    end
  end

  always @(posedge mclk) cyc <= cyc + 1;

  function automatic logic [15:0] pat(input logic [1:0] b, input int c);
    return {b, 5'h15, 9'(c)};
  endfunction

  // idle data lines toggle so a stale value is never mistaken for data
  task automatic drive(input logic v, input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic [15:0] d);
    @(posedge mclk);
    cmd_valid <= v;
    cmd_code <= c;
    cmd_bank <= b;
    cmd_addr <= a;
    dq_in <= d;
  endtask

  task automatic activate(input logic [1:0] b, input logic [12:0] r);
    int i;
    if (open_b[b] && open_row[b] !== r) begin
      drive(1'b1, sdram_burst_pkg::CMD_PRECHARGE, b, 13'h0, ~dq_in);
      open_b[b] = 1'b0;
    end
    for (i = 0; i < 64 && (cyc - last_act[b] < SAME_BANK_CYC || cyc - last_any < OTHER_BANK_CYC); i++)
      drive(1'b0, sdram_burst_pkg::CMD_NOP, 2'h0, 13'h0, ~dq_in);
    drive(1'b1, sdram_burst_pkg::CMD_ACTIVE, b, r, ~dq_in);
    last_act[b] = cyc;
    last_any = cyc;
    open_b[b] = 1'b1;
    open_row[b] = r;
    drive(1'b0, sdram_burst_pkg::CMD_NOP, 2'h0, 13'h0, ~dq_in);
  endtask

  task automatic access(input logic [2:0] c, input logic [1:0] b, input logic [8:0] col, input int nb,
                        input logic [15:0] xv, input logic term);
    int i;
    for (i = 0; i < 64 && cyc - last_act[b] < ROW_COL_CYC; i++)
      drive(1'b0, sdram_burst_pkg::CMD_NOP, 2'h0, 13'h0, ~dq_in);
    for (i = 0; i < nb; i++)
      drive(i == 0, c, b, {4'h0, col}, pat(b, col + i) ^ xv);
    if (term)
      drive(1'b1, sdram_burst_pkg::CMD_TERM, b, 13'h0, pat(b, col + nb) ^ xv);
    drive(1'b0, sdram_burst_pkg::CMD_NOP, 2'h0, 13'h0, ~dq_in);
  endtask
endmodule

// [bench/sdram_burst_tb_top.sv]
/*
  Self-checking bench: mode word, column order, read latency, write-single
  mode and status flags of the burst sequencer.
  Assumes sdram_ctrl_model drives the command and write-data pins.
*/
`timescale 1ns/1ps
module sdram_burst_tb_top;
  typedef struct packed {
    logic [2:0] blen;
    logic ord;
    logic [2:0] lat;
    logic [8:0] st;
    logic [9:0] len;
  } row_t;
  logic mclk;
  logic nrst;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic cmd_valid;
  logic [2:0] cmd_code;
  logic [sdram_burst_pkg::BANK_W-1:0] cmd_bank;
  logic [sdram_burst_pkg::ROW_W-1:0] cmd_addr;
  logic [sdram_burst_pkg::DATA_W-1:0] dq_in;
  logic [sdram_burst_pkg::DATA_W-1:0] dq_out;
  logic dq_oe;
  logic [15:0] exp_mem [512];
  logic [31:0] rd_val;
  int fail_count;
  int check_count;
  row_t rows [9];

  sdram_burst u_sdram_burst (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe));
  sdram_ctrl_model u_sdram_ctrl_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .dq_in(dq_in));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic rd_check(input row_t r, input logic ws);
    int i;
    int m;
    int n;
    logic [8:0] c;
    logic [8:0] mask;
    m = int'(r.lat);
    n = (r.len == 10'h200) ? 4 : int'(r.len);
    mask = 9'(r.len - 10'h001);
    reg_write(sdram_burst_pkg::REG_MODE, {22'h0, ws, 2'h0, r.lat, r.ord, r.blen});
    u_sdram_ctrl_model.access(sdram_burst_pkg::CMD_READ, 2'h0, r.st, 1, 16'h0, 1'b0);
    for (i = 1; i <= m + n; i++) begin
      @(posedge mclk);
      #1;
      check(dq_oe, (i >= m - 1) && (i < m + n || r.len == 10'h200));
      if (i >= m) begin
        c = r.ord ? (r.st ^ 9'(i - m)) : (r.st + 9'(i - m));
        c = (r.st & ~mask) | (c & mask);
        check(dq_out, exp_mem[c]);
      end
    end
    if (r.len == 10'h200) begin
      u_sdram_ctrl_model.drive(1'b1, sdram_burst_pkg::CMD_TERM, 2'h0, 13'h0, ~dq_in);
      u_sdram_ctrl_model.drive(1'b0, sdram_burst_pkg::CMD_NOP, 2'h0, 13'h0, ~dq_in);
      for (i = 0; i < 8 && dq_oe !== 1'b0; i++)
        @(posedge mclk);
      #1;
      check(dq_oe, 1'b0);
    end
  endtask

  initial begin
    int i;
    nrst = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    fail_count = 0;
    check_count = 0;
    // only defined length codes are ever programmed
    rows = '{'{3'h0, 1'b1, 3'h2, 9'h005, 10'h001}, '{3'h1, 1'b0, 3'h3, 9'h001, 10'h002},
             '{3'h1, 1'b1, 3'h2, 9'h002, 10'h002}, '{3'h2, 1'b0, 3'h2, 9'h001, 10'h004},
             '{3'h2, 1'b1, 3'h2, 9'h001, 10'h004}, '{3'h2, 1'b1, 3'h3, 9'h007, 10'h004},
             '{3'h3, 1'b0, 3'h3, 9'h00D, 10'h008}, '{3'h3, 1'b1, 3'h2, 9'h00D, 10'h008},
             '{3'h7, 1'b0, 3'h3, 9'h1FE, 10'h200}};
    repeat (11) @(posedge mclk);
    #1;
    check(dq_oe, 1'b0);
    check(reg_rdata, 32'h0);
    @(posedge mclk);
    nrst <= 1'b1;
    reg_read(sdram_burst_pkg::REG_MODE);
    check(rd_val, {22'h0, sdram_burst_pkg::MODE_RESET});
    reg_write(4'h8, 32'h3FF);
    reg_read(4'h8);
    check(rd_val, 32'h0);
    reg_read(sdram_burst_pkg::REG_MODE);
    check(rd_val, {22'h0, sdram_burst_pkg::MODE_RESET});
    u_sdram_ctrl_model.activate(2'h0, 13'h0);
    reg_read(sdram_burst_pkg::REG_STATUS);
    check(rd_val[7:4], 4'h1);
    // fill the whole page of bank 0 so every bank 0 read below has known data
    reg_write(sdram_burst_pkg::REG_MODE, 32'h027);
    u_sdram_ctrl_model.access(sdram_burst_pkg::CMD_WRITE, 2'h0, 9'h000, 512, 16'h0, 1'b1);
    for (i = 0; i < 512; i++)
      exp_mem[i] = u_sdram_ctrl_model.pat(2'h0, i);
    foreach (rows[j])
      rd_check(rows[j], 1'b0);
    // later write beats carry inverted data that must not land
    reg_write(sdram_burst_pkg::REG_MODE, 32'h222);
    u_sdram_ctrl_model.access(sdram_burst_pkg::CMD_WRITE, 2'h0, 9'h009, 4, 16'hFFFF, 1'b0);
    exp_mem[9] = exp_mem[9] ^ 16'hFFFF;
    rd_check(row_t'{3'h2, 1'b0, 3'h2, 9'h008, 10'h004}, 1'b1);
    u_sdram_ctrl_model.access(sdram_burst_pkg::CMD_READ, 2'h2, 9'h000, 1, 16'h0, 1'b0);
    reg_read(sdram_burst_pkg::REG_STATUS);
    check(rd_val[8], 1'b1);
    reg_write(sdram_burst_pkg::REG_STATUS, 32'h100);
    reg_read(sdram_burst_pkg::REG_STATUS);
    check(rd_val[8], 1'b0);
    repeat (12) @(posedge mclk);
    reg_write(sdram_burst_pkg::REG_MODE, 32'h0A2);
    reg_read(sdram_burst_pkg::REG_STATUS);
    check(rd_val[3], 1'b1);
    u_sdram_ctrl_model.access(sdram_burst_pkg::CMD_READ, 2'h0, 9'h000, 1, 16'h0, 1'b0);
    for (i = 0; i < 6; i++) begin
      @(posedge mclk);
      #1;
      check(dq_oe, 1'b0);
    end
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check(dq_oe, 1'b0);
    @(posedge mclk);
    nrst <= 1'b1;
    reg_read(sdram_burst_pkg::REG_MODE);
    check(rd_val, {22'h0, sdram_burst_pkg::MODE_RESET});
    report_and_stop();
  end
endmodule
